// ---- rpd_defines.vh ----
`ifndef RPD_DEFINES_VH
`define RPD_DEFINES_VH
// Register addresses
`define RPD_ADDR_RX_BG 8'h1A
`define RPD_ADDR_TUNE_CAP 8'h1B
`define RPD_ADDR_VAR_HI 8'h1C
`define RPD_ADDR_VAR_LO 8'h1D
`define RPD_ADDR_REF1_CTRL 8'h1E
`define RPD_ADDR_FRAC_HI 8'h1F
`define RPD_ADDR_FRAC_MID 8'h20
`define RPD_ADDR_FRAC_LO 8'h21
`define RPD_ADDR_INT 8'h22
`define RPD_ADDR_MOD_HI 8'h23
`define RPD_ADDR_MOD_MID 8'h24
`define RPD_ADDR_MOD_LO 8'h25
`define RPD_ADDR_REF2_CTRL 8'h26
// Writable bit masks of each register
`define RPD_MASK_RX_BG 8'hFF
`define RPD_MASK_TUNE_CAP 8'hFF
`define RPD_MASK_VAR_HI 8'hFF
`define RPD_MASK_VAR_LO 8'hFE
`define RPD_MASK_REF1_CTRL 8'hF7
`define RPD_MASK_FRAC_HI 8'hFF
`define RPD_MASK_FRAC_MID 8'hFF
`define RPD_MASK_FRAC_LO 8'hF0
`define RPD_MASK_INT 8'hFC
`define RPD_MASK_MOD_HI 8'hFF
`define RPD_MASK_MOD_MID 8'hFF
`define RPD_MASK_MOD_LO 8'hF0
`define RPD_MASK_REF2_CTRL 8'hF0
// Reset values
`define RPD_RST_RX_BG 8'h00
`define RPD_RST_TUNE_CAP 8'h80
`define RPD_RST_VAR_HI 8'h00
`define RPD_RST_VAR_LO 8'h00
`define RPD_RST_REF1_CTRL 8'h30
`define RPD_RST_FRAC_HI 8'h40
`define RPD_RST_FRAC_MID 8'h00
`define RPD_RST_FRAC_LO 8'h00
`define RPD_RST_INT 8'h40
`define RPD_RST_MOD_HI 8'h80
`define RPD_RST_MOD_MID 8'h00
`define RPD_RST_MOD_LO 8'h00
`define RPD_RST_REF2_CTRL 8'hB0
// Field positions
`define RPD_BIT_RX_RESET 7
`define RPD_BIT_PD_OPTION 1
`define RPD_BIT_BG_MANUAL 0
`define RPD_BIT_CAP_AUTO 7
`define RPD_BIT_VAR_MANUAL 6
`define RPD_BIT_DOUBLER 2
`define RPD_BIT_OSC_BYPASS 1
`define RPD_BIT_DIV_MANUAL 7
`define RPD_BIT_SDM_BYPASS 6
`define RPD_BIT_SDM_RUN 5
`define RPD_BIT_REF_ENABLE 4
`define RPD_BIT_DITHER_OFF 2
// Count of cycles the receiver reset pulse is held
`define RPD_RX_RESET_CYCLES 1
`endif

// ---- rpd_host.sv ----
`default_nettype none
// Host on the register port; released lines show inverted junk, never the old value
module rpd_host (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {wr_en, rd_en, addr, wr_data} = '0;
    end
    // One access, entered and left at a falling edge; read data taken a cycle later
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        wr_en = w;
        rd_en = !w;
        addr = a;
        wr_data = (a == 8'h23) ? {1'b0, d[6:0]} : d;
        @(posedge clk);
        @(negedge clk);
        {wr_en, rd_en} = 2'b00;
        addr = ~addr;
        wr_data = ~wr_data;
        @(posedge clk);
        @(negedge clk);
        q = rd_data;
    endtask
endmodule // rpd_host
`default_nettype wire

// ---- rpd_properties.sv ----
`default_nettype none
// Decoded controls lag an accepted write by two enabled edges
module rpd_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rx_reset,
    input wire logic cap_manual,
    input wire logic div_manual,
    input wire logic sdm_reset,
    input wire logic [12:0] varactor_word,
    input wire logic [2:0] low_rate_div,
    input wire logic [5:0] first_ref_integer_div
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Write as the bank takes it; frozen edges take nothing
    wire logic w = clk_en && wr_en;
    ////////////////////////////////////////
    a_div_select: assert property (
        w && addr == 8'h1E ##1 clk_en[*2] |-> div_manual == $past(wr_data[7], 2))
        else $error("divider select wrong");
    a_sdm_hold: assert property (
        w && addr == 8'h1E ##1 clk_en[*2] |-> sdm_reset == !$past(wr_data[5], 2))
        else $error("modulator hold wrong");
    a_low_rate: assert property (
        w && addr == 8'h1E ##1 clk_en[*2] |-> low_rate_div ==
        ($past(wr_data[1], 2) ? ($past(wr_data[0], 2) ? 3'h4 : 3'h2) : 3'h1))
        else $error("low rate divider wrong");
    a_cap_auto: assert property (
        w && addr == 8'h1B ##1 clk_en[*2] |-> cap_manual == !$past(wr_data[7], 2))
        else $error("tuning cap select wrong");
    a_var_low: assert property (
        w && addr == 8'h1D ##1 clk_en[*2] |-> varactor_word[4:0] == $past(wr_data[7:3], 2))
        else $error("varactor low bits wrong");
    a_int_div: assert property (
        w && addr == 8'h22 ##1 clk_en[*2] |-> first_ref_integer_div == $past(wr_data[7:2], 2))
        else $error("integer divide wrong");
    a_rx_pulse: assert property (
        w && addr == 8'h1A && wr_data[7] ##1 clk_en[*2] |-> rx_reset ##1 !rx_reset)
        else $error("receiver reset pulse wrong");
    a_unmapped_read: assert property (
        clk_en && rd_en && (addr < 8'h1A || addr > 8'h26) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
endmodule // rpd_props
bind rpd_regs rpd_props u_props (.clk, .nrst, .clk_en, .wr_en, .rd_en, .addr, .wr_data,
    .rd_data, .rx_reset, .cap_manual, .div_manual, .sdm_reset, .varactor_word,
    .low_rate_div, .first_ref_integer_div);
`default_nettype wire

// ---- rpd_regs.v ----
// Functional notes
// - Receiver reset bit pulses, then self-clears.
// - Five-bit band gap trim, default zero.
// - Band gap auto unless manual bit set.
// - Power-down option gates receiver enable bits.
// - Second receiver off when bit clear, option set.
// - Tuning cap auto by default, else field.
// - Tuning cap code default zero, higher faster.
// - Varactor word drives varactor when manual set.
// - Thirteen-bit varactor word split, default zero.
// - Doubler bypassed when bit zero.
// - Oscillator bypassed when bit one.
// - Divider from pins or from registers.
// - Modulator bypass gives integer division only.
// - Modulator held reset while run bit clear.
// - Dither off for both modulators when set.
// - Low-rate divider 1,1,2,4 on all-ones pins.
// - Twenty-bit fraction, default 262144.
// - Six-bit integer divide, default 16.
// - Nineteen-bit modulus, default zero.
// - First receiver off when bit clear, option set.
`include "rpd_defines.vh"
`default_nettype none
module rpd_regs (
    input wire clk,
    input wire nrst,
    input wire clk_en,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire [3:0] first_ref_sel_pins,
    input wire [3:0] second_ref_sel_pins,
    output reg rx_reset,
    output reg bg_manual,
    output reg [4:0] bg_trim,
    output reg cap_manual,
    output reg [5:0] tune_cap,
    output reg var_manual,
    output reg [12:0] varactor_word,
    output reg doubler_en,
    output reg osc_bypass,
    output reg div_manual,
    output reg sdm_int_only,
    output reg sdm_reset,
    output reg dither_off,
    output reg first_rx_pd,
    output reg second_rx_pd,
    output reg [2:0] low_rate_div,
    output reg low_rate_active,
    output reg [19:0] first_ref_fraction,
    output reg [5:0] first_ref_integer_div,
    output reg [18:0] first_ref_modulus
);

//////////////////////////////////////////////////////////////////////////////
// Register index decode, shared by write and read paths
// Unmapped addresses decode to index F, which no byte uses.
function [3:0] rpd_index;
    input [7:0] a;
    begin
        case (a)
            `RPD_ADDR_RX_BG: rpd_index = 4'h0;
            `RPD_ADDR_TUNE_CAP: rpd_index = 4'h1;
            `RPD_ADDR_VAR_HI: rpd_index = 4'h2;
            `RPD_ADDR_VAR_LO: rpd_index = 4'h3;
            `RPD_ADDR_REF1_CTRL: rpd_index = 4'h4;
            `RPD_ADDR_FRAC_HI: rpd_index = 4'h5;
            `RPD_ADDR_FRAC_MID: rpd_index = 4'h6;
            `RPD_ADDR_FRAC_LO: rpd_index = 4'h7;
            `RPD_ADDR_INT: rpd_index = 4'h8;
            `RPD_ADDR_MOD_HI: rpd_index = 4'h9;
            `RPD_ADDR_MOD_MID: rpd_index = 4'hA;
            `RPD_ADDR_MOD_LO: rpd_index = 4'hB;
            `RPD_ADDR_REF2_CTRL: rpd_index = 4'hC;
            default: rpd_index = 4'hF;
        endcase
    end
endfunction

// Writable mask per index; cleared bits never store
function [7:0] rpd_mask;
    input [3:0] i;
    begin
        case (i)
            4'h0: rpd_mask = `RPD_MASK_RX_BG;
            4'h1: rpd_mask = `RPD_MASK_TUNE_CAP;
            4'h2: rpd_mask = `RPD_MASK_VAR_HI;
            4'h3: rpd_mask = `RPD_MASK_VAR_LO;
            4'h4: rpd_mask = `RPD_MASK_REF1_CTRL;
            4'h5: rpd_mask = `RPD_MASK_FRAC_HI;
            4'h6: rpd_mask = `RPD_MASK_FRAC_MID;
            4'h7: rpd_mask = `RPD_MASK_FRAC_LO;
            4'h8: rpd_mask = `RPD_MASK_INT;
            4'h9: rpd_mask = `RPD_MASK_MOD_HI;
            4'hA: rpd_mask = `RPD_MASK_MOD_MID;
            4'hB: rpd_mask = `RPD_MASK_MOD_LO;
            4'hC: rpd_mask = `RPD_MASK_REF2_CTRL;
            default: rpd_mask = 8'h00;
        endcase
    end
endfunction

// Reset value per index
function [7:0] rpd_reset;
    input [3:0] i;
    begin
        case (i)
            4'h0: rpd_reset = `RPD_RST_RX_BG;
            4'h1: rpd_reset = `RPD_RST_TUNE_CAP;
            4'h2: rpd_reset = `RPD_RST_VAR_HI;
            4'h3: rpd_reset = `RPD_RST_VAR_LO;
            4'h4: rpd_reset = `RPD_RST_REF1_CTRL;
            4'h5: rpd_reset = `RPD_RST_FRAC_HI;
            4'h6: rpd_reset = `RPD_RST_FRAC_MID;
            4'h7: rpd_reset = `RPD_RST_FRAC_LO;
            4'h8: rpd_reset = `RPD_RST_INT;
            4'h9: rpd_reset = `RPD_RST_MOD_HI;
            4'hA: rpd_reset = `RPD_RST_MOD_MID;
            4'hB: rpd_reset = `RPD_RST_MOD_LO;
            4'hC: rpd_reset = `RPD_RST_REF2_CTRL;
            default: rpd_reset = 8'h00;
        endcase
    end
endfunction

//////////////////////////////////////////////////////////////////////////////
// Register storage, one byte per index
// Thirteen bytes, indices 0 to C; the last byte keeps only its top nibble.
reg [7:0] regs_q [0:12];
wire [3:0] wr_idx;
wire [3:0] rd_idx;
assign wr_idx = rpd_index(addr);
assign rd_idx = rpd_index(addr);

// Each byte stores only its writable bits
// A write to the receiver byte in its clearing cycle wins, so a fresh
// reset request is never lost.
genvar gi;
generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_reg
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                regs_q[gi] <= rpd_reset(gi[3:0]);
            end else if (clk_en) begin
                if (wr_en && wr_idx == gi[3:0]) begin
                    regs_q[gi] <= wr_data & rpd_mask(gi[3:0]);
                end else if (gi == 0) begin
                    // Reset request bit lasts one enabled cycle only
                    regs_q[gi] <= regs_q[gi] & 8'h7F;
                end
            end
        end
    end
endgenerate

//////////////////////////////////////////////////////////////////////////////
// Selection pins come from outside: three flops, accept when last two agree
// The agreeing stage rejects a one-cycle glitch on a pin; the cost is
// a few cycles of delay before low_rate_active follows the pins.
reg [3:0] a_s1_q, a_s2_q, a_s3_q, a_pins_q;
reg [3:0] b_s1_q, b_s2_q, b_s3_q, b_pins_q;
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        a_s1_q <= 4'h0;
        a_s2_q <= 4'h0;
        a_s3_q <= 4'h0;
        a_pins_q <= 4'h0;
        b_s1_q <= 4'h0;
        b_s2_q <= 4'h0;
        b_s3_q <= 4'h0;
        b_pins_q <= 4'h0;
    end else if (clk_en) begin
        a_s1_q <= first_ref_sel_pins;
        a_s2_q <= a_s1_q;
        a_s3_q <= a_s2_q;
        b_s1_q <= second_ref_sel_pins;
        b_s2_q <= b_s1_q;
        b_s3_q <= b_s2_q;
        if (a_s2_q == a_s3_q) begin
            a_pins_q <= a_s3_q;
        end
        if (b_s2_q == b_s3_q) begin
            b_pins_q <= b_s3_q;
        end
    end
end

//////////////////////////////////////////////////////////////////////////////
// Read mux; unmapped addresses read zero, no side effects on read
// Read data holds between reads so a slow host may sample it late.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rd_data <= 8'h00;
    end else if (clk_en && rd_en) begin
        if (rd_idx == 4'hF) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= regs_q[rd_idx];
        end
    end
end

//////////////////////////////////////////////////////////////////////////////
// Decoded controls, all registered so outputs come from flops.
// One cycle of latency behind the bytes keeps the paths short.
// Byte positions in the storage array
localparam [3:0] IDX_RX_BG = 4'h0;
localparam [3:0] IDX_TUNE_CAP = 4'h1;
localparam [3:0] IDX_VAR_HI = 4'h2;
localparam [3:0] IDX_VAR_LO = 4'h3;
localparam [3:0] IDX_REF1_CTRL = 4'h4;
localparam [3:0] IDX_FRAC_HI = 4'h5;
localparam [3:0] IDX_FRAC_MID = 4'h6;
localparam [3:0] IDX_FRAC_LO = 4'h7;
localparam [3:0] IDX_INT = 4'h8;
localparam [3:0] IDX_MOD_HI = 4'h9;
localparam [3:0] IDX_MOD_MID = 4'hA;
localparam [3:0] IDX_MOD_LO = 4'hB;
localparam [3:0] IDX_REF2_CTRL = 4'hC;

wire pd_opt;
assign pd_opt = regs_q[IDX_RX_BG][`RPD_BIT_PD_OPTION];

// Next values of the derived words
wire second_rx_pd_d;
wire first_rx_pd_d;
wire [19:0] first_ref_fraction_d;
wire [18:0] first_ref_modulus_d;
reg [2:0] low_rate_div_d;
// Power-down only honoured while the option bit is set
assign second_rx_pd_d = pd_opt & ~regs_q[IDX_REF1_CTRL][`RPD_BIT_REF_ENABLE];
assign first_rx_pd_d = pd_opt & ~regs_q[IDX_REF2_CTRL][`RPD_BIT_REF_ENABLE];
// Multi-byte words assemble live; software writes all bytes before use
assign first_ref_fraction_d = {regs_q[IDX_FRAC_HI], regs_q[IDX_FRAC_MID],
    regs_q[IDX_FRAC_LO][7:4]};
// Top bit of the modulus high byte is excluded; software zeroes it
assign first_ref_modulus_d = {regs_q[IDX_MOD_HI][6:0], regs_q[IDX_MOD_MID],
    regs_q[IDX_MOD_LO][7:4]};

// Low-rate divider code to divide value; codes 00 and 01 both divide by one
always @* begin
    case (regs_q[IDX_REF1_CTRL][1:0])
        2'b10: low_rate_div_d = 3'h2;
        2'b11: low_rate_div_d = 3'h4;
        default: low_rate_div_d = 3'h1;
    endcase
end

// Receiver reset pulse and band gap control
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rx_reset <= 1'b0;
        bg_manual <= 1'b0;
        bg_trim <= 5'h00;
    end else if (clk_en) begin
        rx_reset <= regs_q[IDX_RX_BG][`RPD_BIT_RX_RESET];
        bg_manual <= regs_q[IDX_RX_BG][`RPD_BIT_BG_MANUAL];
        bg_trim <= regs_q[IDX_RX_BG][6:2];
    end
end

// Oscillator tuning; the auto bit is inverted so manual is active high
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        cap_manual <= 1'b0;
        tune_cap <= 6'h00;
        var_manual <= 1'b0;
        varactor_word <= 13'h0000;
        doubler_en <= 1'b0;
        osc_bypass <= 1'b0;
    end else if (clk_en) begin
        cap_manual <= ~regs_q[IDX_TUNE_CAP][`RPD_BIT_CAP_AUTO];
        tune_cap <= regs_q[IDX_TUNE_CAP][5:0];
        var_manual <= regs_q[IDX_TUNE_CAP][`RPD_BIT_VAR_MANUAL];
        varactor_word <= {regs_q[IDX_VAR_HI], regs_q[IDX_VAR_LO][7:3]};
        // Doubler and bypass are independent; both set sends the pin clock doubled
        doubler_en <= regs_q[IDX_VAR_LO][`RPD_BIT_DOUBLER];
        osc_bypass <= regs_q[IDX_VAR_LO][`RPD_BIT_OSC_BYPASS];
    end
end

// First reference modulator control; the dither bit serves both references
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        div_manual <= 1'b0;
        sdm_int_only <= 1'b0;
        sdm_reset <= 1'b0;
        dither_off <= 1'b0;
    end else if (clk_en) begin
        div_manual <= regs_q[IDX_REF1_CTRL][`RPD_BIT_DIV_MANUAL];
        sdm_int_only <= regs_q[IDX_REF1_CTRL][`RPD_BIT_SDM_BYPASS];
        sdm_reset <= ~regs_q[IDX_REF1_CTRL][`RPD_BIT_SDM_RUN];
        dither_off <= regs_q[IDX_REF1_CTRL][`RPD_BIT_DITHER_OFF];
    end
end

// Receiver power-down
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        first_rx_pd <= 1'b0;
        second_rx_pd <= 1'b0;
    end else if (clk_en) begin
        // Clearing the option bit wakes both receivers at once
        first_rx_pd <= first_rx_pd_d;
        second_rx_pd <= second_rx_pd_d;
    end
end

// Low-rate mode: divider value, and whether the pins put it in effect
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        low_rate_div <= 3'h1;
        low_rate_active <= 1'b0;
    end else if (clk_en) begin
        low_rate_div <= low_rate_div_d;
        low_rate_active <= (a_pins_q == 4'hF) | (b_pins_q == 4'hF);
    end
end

// Divider ratio words; they change byte by byte, with no shadow copy
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        first_ref_fraction <= 20'h40000;
        first_ref_integer_div <= 6'h10;
        first_ref_modulus <= 19'h00000;
    end else if (clk_en) begin
        first_ref_fraction <= first_ref_fraction_d;
        first_ref_integer_div <= regs_q[IDX_INT][7:2];
        first_ref_modulus <= first_ref_modulus_d;
    end
end

endmodule // rpd_regs
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] first_ref_sel_pins = 4'h0;
    logic [3:0] second_ref_sel_pins = 4'h0;
    wire logic [7:0] addr, wr_data, rd_data;
    wire logic wr_en, rd_en, rx_reset, bg_manual, cap_manual, var_manual, doubler_en;
    wire logic osc_bypass, div_manual, sdm_int_only, sdm_reset, dither_off;
    wire logic first_rx_pd, second_rx_pd, low_rate_active;
    wire logic [4:0] bg_trim;
    wire logic [5:0] tune_cap, first_ref_integer_div;
    wire logic [12:0] varactor_word;
    wire logic [2:0] low_rate_div;
    wire logic [19:0] first_ref_fraction;
    wire logic [18:0] first_ref_modulus;
    int failures = 0;
    int check_count = 0;
    logic [31:0] s = 32'h0000_1550;
    logic [7:0] a, d, q;
    logic [8:0] pt [3] = '{9'h1F0, 9'h17F, 9'h07E};
    logic [7:0] mem [13];
    // Defaults from receiver_bandgap_ctrl up to 0x26
    localparam logic [7:0] rst_val [13] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h30, 8'h40,
        8'h00, 8'h00, 8'h40, 8'h80, 8'h00, 8'h00, 8'hB0};
    // Bits kept; receiver_bandgap_ctrl bit7 self-clears and the host never sets first_ref_modulus_high bit7
    localparam logic [7:0] keep_mask [13] = '{8'h7F, 8'hFF, 8'hFF, 8'hFE, 8'hF7, 8'hFF,
        8'hFF, 8'hF0, 8'hFC, 8'h7F, 8'hFF, 8'hF0, 8'hF0};
    always #25 clk = ~clk;
    rpd_regs dut (.*);
    rpd_host host (.clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data);
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        return (ad >= 8'h1A && ad <= 8'h26) ? mem[ad - 8'h1A] : 8'h00;
    endfunction
    // Write through the host and mirror it; unmapped writes are dropped
    task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
        host.xfer(1'b1, ad, dd, q);
        if (ad >= 8'h1A && ad <= 8'h26) mem[ad - 8'h1A] = dd & keep_mask[ad - 8'h1A];
    endtask
    // Decoded outputs against the model bytes
    task automatic cmp_outs;
        logic [2:0] lr;
        lr = mem[4][1] ? (mem[4][0] ? 3'h4 : 3'h2) : 3'h1;
        chk("rx_osc", {bg_manual, bg_trim, cap_manual, tune_cap, var_manual,
            varactor_word, doubler_en, osc_bypass}, {mem[0][0], mem[0][6:2], !mem[1][7],
            mem[1][5:0], mem[1][6], mem[2], mem[3][7:1]});
        chk("ref1", {div_manual, sdm_int_only, sdm_reset, dither_off, first_rx_pd,
            second_rx_pd, low_rate_div}, {mem[4][7:6], !mem[4][5], mem[4][2],
            mem[0][1] & !mem[12][4], mem[0][1] & !mem[4][4], lr});
        chk("ratio", {first_ref_fraction, first_ref_integer_div, first_ref_modulus},
            {mem[5], mem[6], mem[7][7:4], mem[8][7:2], mem[9][6:0], mem[10], mem[11][7:4]});
    endtask
    // Hang guard, far beyond the run's length
    initial begin
        #1ms;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        mem = rst_val;
        @(negedge clk);
        cmp_outs();
        for (int i = 0; i < 13; i++) begin
            host.xfer(1'b0, 8'(8'h1A + i), 8'h00, q);
            chk("reset value", q, rst_val[i]);
        end
        $display("test reset values done");
        // Random traffic including the unmapped neighbours 0x19 and 0x27
        for (int n = 0; n < 80; n++) begin
            a = 8'(8'h19 + rnd() % 15);
            d = 8'(rnd());
            wr(a, (a == 8'h1A) ? (d & 8'h7F) : d);
            a = 8'(8'h19 + rnd() % 15);
            host.xfer(1'b0, a, 8'h00, q);
            chk("readback", q, exp_rd(a));
            cmp_outs();
        end
        $display("test random traffic done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h1E, (8'(rnd()) & 8'hFC) | 8'(c));
            @(negedge clk);
            cmp_outs();
        end
        $display("test low rate codes done");
        wr(8'h1A, 8'h80 | 8'(rnd()));
        chk("rx_reset high", rx_reset, 1'b1);
        @(negedge clk);
        chk("rx_reset low", rx_reset, 1'b0);
        host.xfer(1'b0, 8'h1A, 8'h00, q);
        chk("rx_reset bit", q, exp_rd(8'h1A));
        $display("test receiver reset done");
        clk_en = 1'b0;
        host.xfer(1'b1, 8'h22, ~mem[8], q);
        clk_en = 1'b1;
        host.xfer(1'b0, 8'h22, 8'h00, q);
        chk("frozen write", q, exp_rd(8'h22));
        cmp_outs();
        $display("test clock enable done");
        for (int i = 0; i < 3; i++) begin
            {first_ref_sel_pins, second_ref_sel_pins} = pt[i][7:0];
            repeat (8) @(negedge clk);
            chk("low rate active", low_rate_active, pt[i][8]);
        end
        $display("test select pins done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
